// *** inc/status_pkg.sv ***
// Package with constants and carrier types for the status select and power-save block
package status_pkg;
  localparam int CHANNELS = 16;
  localparam int SR_WIDTH = 17;
  localparam logic [1:0] SEL_NONE  = 2'h0;
  localparam logic [1:0] SEL_OPEN  = 2'h1;
  localparam logic [1:0] SEL_SHORT = 2'h2;
  localparam logic [1:0] SEL_LEAK  = 2'h3;
  localparam logic [1:0] CUR_OFF   = 2'h0;
  localparam int SR_TOP_BIT = 16;
  localparam logic [15:0] ONOFF_RESET = 16'h0000;
  localparam logic [15:0] CTRL_RESET  = 16'hE67F;
  localparam int CTRL_SEL_LO   = 7;
  localparam int CTRL_THR_LO   = 9;
  localparam int CTRL_CUR_LO   = 11;
  localparam int CTRL_WIN_LO   = 13;
  localparam int CTRL_PS_BIT   = 15;
  localparam int CLK_MHZ        = 200;
  localparam int BLIND_NS       = 500;
  localparam int BLIND_CYCLES   = (BLIND_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_US        = 20;
  localparam int WAKE_CYCLES    = WAKE_US * CLK_MHZ;
  localparam int OSC_DIV        = 10;
  localparam int WIN0_OSC       = 17;
  localparam int WIN1_OSC       = 33;
  localparam int WIN2_OSC       = 65;
  localparam int WIN3_OSC       = 129;

  // Per-channel comparator results from the analog front end
  typedef struct packed {
    logic [15:0] below_open;
    logic [3:0][15:0] above_short;
    logic [15:0] leak;
  } detect_t;

  // Global flags
  typedef struct packed {
    logic thermal_error_flag;
    logic pre_thermal_warning;
    logic ref_short_flag;
  } flags_t;
endpackage

// *** logic/sync2.sv ***
// Two-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // Levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

// *** logic/win_timer.sv ***
// Down counter that pulses done when a loaded count runs out
`timescale 1ns/1ps
`default_nettype none
module win_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // Control
  input  wire logic         start,
  input  wire logic         abort,
  input  wire logic [W-1:0] count,
  output logic              busy,
  output logic              done
);
  logic [W-1:0] cnt_r;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_r <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        cnt_r <= count;
        busy  <= 1'b1;
      end
      else if (abort)
        busy <= 1'b0;
      else if (busy)
      begin
        if (cnt_r <= W'(1))
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        cnt_r <= cnt_r - W'(1);
      end
    end
  end
endmodule
`default_nettype wire

// *** logic/status_select.sv ***
// Status word selection, detector capture and power-save control of the LED sink driver
//
// Overview of operation
// - Select 00 leaves shift register untouched
// - Select 01 loads open-detect or thermal word
// - Thermal shutdown forces outputs off, open reads ones
// - Select 10 loads short-detect or warning word
// - Short bit follows chosen threshold comparator
// - Select 11 loads leakage or reference-short word
// - Leakage bit set for leaking output that is switched off
// - Power-save only while enable bit is one
// - Enter power-save on all-zero on/off latch
// - Stay in power-save until shift clock rises
// - Enable zero never enters power-save
// - Open bit set when output below threshold
// - Disabled channels report zero open and short bits unless invisible mode
// - Select 01 captures open word at blank rise
// - Invisible mode captures at window end
// - Ignore detectors 0.5 us after turn-on
// - No detection until wake delay elapses
// - Captured word shifts out on serial output
// - Top bit zero loads status in the same strobe as on/off copy
// - Sink current 00 disables invisible mode
// - Serial output advances each shift clock rise
`timescale 1ns/1ps
`default_nettype none
module status_select
  import status_pkg::*;
#(
  parameter int WAKE_CNT = WAKE_CYCLES
) (
  // Clock and reset
  input  wire logic                 CLK,
  input  wire logic                 RESETN,
  // Serial link pins from the controller
  input  wire logic                 SERIAL_IN,
  input  wire logic                 SHIFT_CLK,
  input  wire logic                 LATCH_STROBE,
  input  wire logic                 BLANK,
  // Analog detector results
  input  wire status_pkg::detect_t  DETECT,
  input  wire status_pkg::flags_t   FLAGS,
  // Outputs
  output logic                      SERIAL_OUT,
  output logic [15:0]               CHANNEL_OUTPUT,
  output logic                      POWER_SAVE,
  output logic                      STATUS_VALID,
  output logic [15:0]               CTRL_WORD
);
  import status_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Synchronisers
  logic [3:0] pins_s;
  logic       sclk_d_r;
  logic       lat_d_r;
  logic       blank_d_r;

  sync2 #(.W(4)) u_sync (
    .clk    (CLK),
    .resetn (RESETN),
    .d      ({SERIAL_IN, SHIFT_CLK, LATCH_STROBE, BLANK}),
    .q      (pins_s)
  );

  wire sin_s     = pins_s[3];
  wire sclk_rise = pins_s[2] & ~sclk_d_r;
  wire lat_rise  = pins_s[1] & ~lat_d_r;
  wire blank_s   = pins_s[0];
  wire blank_rise = blank_s & ~blank_d_r;
  wire blank_fall = ~blank_s & blank_d_r;

  //////////////////////////////////////////////////////////////////////////////
  // Control fields
  logic [SR_WIDTH-1:0] sr_r;
  logic [15:0]         onoff_r;
  logic [15:0]         ctrl_r;
  logic [15:0]         holder_r;
  logic                ps_r;
  logic                hold_valid_r;

  wire [1:0] status_select      = ctrl_r[CTRL_SEL_LO +: 2];
  wire [1:0] short_threshold_sel = ctrl_r[CTRL_THR_LO +: 2];
  wire [1:0] detect_sink_current = ctrl_r[CTRL_CUR_LO +: 2];
  wire [1:0] detect_window_time  = ctrl_r[CTRL_WIN_LO +: 2];
  wire       low_power_enable    = ctrl_r[CTRL_PS_BIT];
  wire       invisible_detection = (detect_sink_current != CUR_OFF);

  function automatic logic [15:0] win_cycles(input logic [1:0] sel);
    int osc;
    osc = WIN0_OSC;
    case (sel)
      2'h0: osc = WIN0_OSC;
      2'h1: osc = WIN1_OSC;
      2'h2: osc = WIN2_OSC;
      default: osc = WIN3_OSC;
    endcase
    return 16'(osc * OSC_DIV);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Detector words
  wire        tsd = FLAGS.thermal_error_flag;
  wire [15:0] mask = invisible_detection ? 16'hFFFF : onoff_r;
  wire [15:0] open_detect  = tsd ? 16'hFFFF : (DETECT.below_open & mask);
  wire [15:0] short_detect = FLAGS.pre_thermal_warning ? 16'hFFFF
                           : (DETECT.above_short[short_threshold_sel] & mask);
  wire [15:0] leakage_detect = FLAGS.ref_short_flag ? 16'hFFFF
                             : (DETECT.leak & ~onoff_r);

  wire [15:0] picked = (status_select == SEL_OPEN)  ? open_detect :
                       (status_select == SEL_SHORT) ? short_detect :
                       leakage_detect;

  //////////////////////////////////////////////////////////////////////////////
  // Blind time after turn-on, wake delay, invisible window
  logic [15:0] blind_r;
  logic [15:0] wake_r;
  wire         blind = (blind_r != 16'h0000);
  wire         waking = (wake_r != 16'h0000);
  wire         det_ok = ~ps_r & ~waking;
  logic        win_busy;
  logic        win_done;

  win_timer #(.W(16)) u_win (
    .clk    (CLK),
    .resetn (RESETN),
    .start  (blank_fall & invisible_detection & det_ok),
    .abort  (blank_rise),
    .count  (win_cycles(detect_window_time)),
    .busy   (win_busy),
    .done   (win_done)
  );

  wire win_stop = win_done | (blank_rise & win_busy);
  wire cap_evt  = invisible_detection ? win_stop : blank_rise;
  wire cap_ok   = cap_evt & det_ok & ~blind & (status_select != SEL_NONE);

  //////////////////////////////////////////////////////////////////////////////
  // Latch strobe decode
  wire        to_ctrl   = sr_r[SR_TOP_BIT];
  wire [15:0] new_onoff = to_ctrl ? onoff_r : sr_r[15:0];
  wire        ps_enter  = lat_rise & (new_onoff == 16'h0000)
                        & (to_ctrl ? sr_r[CTRL_PS_BIT] : low_power_enable);
  wire        load_sid  = lat_rise & ~to_ctrl & (status_select != SEL_NONE);

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      sclk_d_r  <= 1'b0;
      lat_d_r   <= 1'b0;
      // Matches the synchroniser's reset level so no false blank edge follows reset
      blank_d_r <= 1'b0;
    end
    else
    begin
      sclk_d_r  <= pins_s[2];
      lat_d_r   <= pins_s[1];
      blank_d_r <= blank_s;
    end
  end

  // Shift register: shifting and status load never coincide in practice
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      sr_r <= '0;
    else if (load_sid)
      sr_r <= {sr_r[SR_TOP_BIT], holder_r};
    else if (sclk_rise)
      sr_r <= {sr_r[SR_WIDTH-2:0], sin_s};
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      onoff_r <= ONOFF_RESET;
      ctrl_r  <= CTRL_RESET;
    end
    else if (lat_rise)
    begin
      onoff_r <= new_onoff;
      if (to_ctrl)
        ctrl_r <= sr_r[15:0];
    end
  end

  // Power-save holds until the next shift clock rise; wake delay then counts down
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ps_r   <= 1'b0;
      wake_r <= 16'h0000;
    end
    else if (ps_enter)
      ps_r <= 1'b1;
    else if (ps_r && sclk_rise)
    begin
      ps_r   <= 1'b0;
      wake_r <= 16'(WAKE_CNT);
    end
    else if (waking)
      wake_r <= wake_r - 16'h0001;
  end

  // Blind counter restarts whenever a latch strobe adds a channel to the on/off word
  wire [15:0] drive = (tsd || ps_r) ? 16'h0000 : onoff_r;
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      blind_r <= 16'h0000;
    else if (|(new_onoff & ~onoff_r) && lat_rise)
      blind_r <= 16'(BLIND_CYCLES);
    else if (blind)
      blind_r <= blind_r - 16'h0001;
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      holder_r     <= 16'h0000;
      hold_valid_r <= 1'b0;
    end
    else if (cap_ok)
    begin
      holder_r     <= picked;
      hold_valid_r <= 1'b1;
    end
    else if (ps_enter || (ps_r && sclk_rise))
      hold_valid_r <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      SERIAL_OUT     <= 1'b0;
      CHANNEL_OUTPUT <= 16'h0000;
      POWER_SAVE     <= 1'b0;
      STATUS_VALID   <= 1'b0;
      CTRL_WORD      <= CTRL_RESET;
    end
    else
    begin
      SERIAL_OUT     <= sr_r[SR_TOP_BIT];
      CHANNEL_OUTPUT <= drive;
      POWER_SAVE     <= ps_r;
      STATUS_VALID   <= hold_valid_r & ~waking;
      CTRL_WORD      <= ctrl_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_none_keeps_sr: assert property (@(posedge CLK) disable iff (!RESETN)
    (lat_rise && status_select == SEL_NONE && !sclk_rise) |=> sr_r == $past(sr_r))
    else $error("select 00 changed shift register");

  a_sid_load_word: assert property (@(posedge CLK) disable iff (!RESETN)
    load_sid |=> sr_r[15:0] == $past(holder_r))
    else $error("status word not loaded");

  a_thermal_off: assert property (@(posedge CLK) disable iff (!RESETN)
    tsd |=> CHANNEL_OUTPUT == 16'h0000)
    else $error("outputs on during thermal shutdown");

  a_ps_needs_en: assert property (@(posedge CLK) disable iff (!RESETN)
    (lat_rise && !to_ctrl && !low_power_enable) |=> !ps_r)
    else $error("power-save entered while disabled");

  a_ps_enter: assert property (@(posedge CLK) disable iff (!RESETN)
    ps_enter |=> ps_r ##1 POWER_SAVE)
    else $error("power-save not entered");

  a_ps_hold: assert property (@(posedge CLK) disable iff (!RESETN)
    (ps_r && !sclk_rise) |=> ps_r)
    else $error("power-save left without shift clock");

  a_wake_blocks: assert property (@(posedge CLK) disable iff (!RESETN)
    (ps_r && sclk_rise && !ps_enter) |=> !cap_ok [*8])
    else $error("capture during wake delay");

  a_blind_blocks: assert property (@(posedge CLK) disable iff (!RESETN)
    blind |-> !cap_ok)
    else $error("capture inside blind time");

  a_serial_top: assert property (@(posedge CLK) disable iff (!RESETN)
    sclk_rise && !load_sid |=> ##1 SERIAL_OUT == $past(sr_r[SR_TOP_BIT-1], 2))
    else $error("serial output did not advance");

  //////////////////////////////////////////////////////////////////////////////
  // Capture, wake, power-save output, control-write and detector-word guards

  a_valid_wake: assert property (@(posedge CLK) disable iff (!RESETN)
    waking |=> !STATUS_VALID)
    else $error("status flagged valid during wake delay");

  a_ps_out_off: assert property (@(posedge CLK) disable iff (!RESETN)
    ps_r |=> CHANNEL_OUTPUT == 16'h0000)
    else $error("outputs driven in power-save");

  a_ctrl_no_sid: assert property (@(posedge CLK) disable iff (!RESETN)
    (lat_rise && to_ctrl && !sclk_rise) |=> sr_r == $past(sr_r))
    else $error("control write changed shift register");

  a_cap_needs_sel: assert property (@(posedge CLK) disable iff (!RESETN)
    (status_select == SEL_NONE) |-> !cap_ok)
    else $error("capture with no detector selected");

  a_cap_holder: assert property (@(posedge CLK) disable iff (!RESETN)
    cap_ok |=> holder_r == $past(picked))
    else $error("holder missed captured word");

  // Window opens on every blank fall with invisible mode on and detection allowed
  a_win_start: assert property (@(posedge CLK) disable iff (!RESETN)
    (blank_fall && invisible_detection && det_ok) |=> win_busy)
    else $error("detection window did not start");

  a_ref_short_word: assert property (@(posedge CLK) disable iff (!RESETN)
    (FLAGS.ref_short_flag && status_select == SEL_LEAK) |-> picked == 16'hFFFF)
    else $error("reference short did not force all ones");
endmodule
`default_nettype wire

// *** test/host_ctrl.sv ***
// Controller model driving the serial, latch and blanking pins
`timescale 1ns/1ps
`default_nettype none
module host_ctrl (
  // Clock
  input  wire logic CLK,
  // Pins
  input  wire logic SERIAL_OUT,
  output logic      SERIAL_IN,
  output logic      SHIFT_CLK,
  output logic      LATCH_STROBE,
  output logic      BLANK
);
  localparam int HALF = 5;
  initial
  begin
    SERIAL_IN = 1'b0;
    SHIFT_CLK = 1'b0;
    LATCH_STROBE = 1'b0;
    BLANK = 1'b0;
  end
  task automatic wait_c(input int n);
    repeat (n) @(posedge CLK);
  endtask
  // Single link clock period, enough to wake the device
  task automatic sclk();
    wait_c(HALF);
    SHIFT_CLK <= 1'b1;
    wait_c(HALF);
    SHIFT_CLK <= 1'b0;
  endtask
  // 17 bits MSB first; outgoing bit taken just before each rise
  task automatic xfer(input logic [16:0] w, output logic [16:0] r);
    for (int i = 16; i >= 0; i--)
    begin
      SERIAL_IN <= w[i];
      wait_c(HALF);
      r[i] = SERIAL_OUT;
      SHIFT_CLK <= 1'b1;
      wait_c(HALF);
      SHIFT_CLK <= 1'b0;
    end
    // Released line must not keep a stale bit
    SERIAL_IN <= ~w[0];
  endtask
  task automatic latch();
    LATCH_STROBE <= 1'b1;
    wait_c(HALF);
    LATCH_STROBE <= 1'b0;
    wait_c(HALF);
  endtask
  task automatic blank();
    BLANK <= 1'b1;
    wait_c(HALF);
    BLANK <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** test/testbench.sv ***
// Self-checking bench for the status select and power-save block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import status_pkg::*;
  typedef struct packed {
    logic [1:0]  sel;
    logic [1:0]  thr;
    logic [1:0]  cur;
    flags_t      fl;
    logic [15:0] on;
  } row_t;
  localparam int WAKE = 20;
  logic        CLK;
  logic        RESETN;
  logic        SERIAL_IN;
  logic        SHIFT_CLK;
  logic        LATCH_STROBE;
  logic        BLANK;
  logic        SERIAL_OUT;
  logic        POWER_SAVE;
  logic        STATUS_VALID;
  logic [15:0] CHANNEL_OUTPUT;
  logic [15:0] CTRL_WORD;
  logic [15:0] c;
  logic [16:0] r;
  detect_t     DETECT;
  flags_t      FLAGS;
  int          error_cnt = 0;
  int          total_checks = 0;
  row_t        rows [11] = '{
    '{2'h0, 2'h3, 2'h0, 3'h0, 16'h1234},
    '{2'h1, 2'h0, 2'h0, 3'h0, 16'hF0F0},
    '{2'h1, 2'h0, 2'h0, 3'h4, 16'hF0F0},
    '{2'h2, 2'h0, 2'h0, 3'h0, 16'hFF00},
    '{2'h2, 2'h1, 2'h0, 3'h0, 16'hFF00},
    '{2'h2, 2'h2, 2'h0, 3'h0, 16'h0FF0},
    '{2'h2, 2'h3, 2'h0, 3'h0, 16'h0FF0},
    '{2'h2, 2'h3, 2'h0, 3'h2, 16'h0FF0},
    '{2'h3, 2'h0, 2'h0, 3'h0, 16'h0F0F},
    '{2'h3, 2'h0, 2'h0, 3'h1, 16'h0F0F},
    '{2'h1, 2'h0, 2'h1, 3'h0, 16'h00FF}
  };
  host_ctrl host (.CLK(CLK), .SERIAL_OUT(SERIAL_OUT), .SERIAL_IN(SERIAL_IN),
    .SHIFT_CLK(SHIFT_CLK), .LATCH_STROBE(LATCH_STROBE), .BLANK(BLANK));
  status_select #(.WAKE_CNT(WAKE)) dut (.CLK(CLK), .RESETN(RESETN),
    .SERIAL_IN(SERIAL_IN), .SHIFT_CLK(SHIFT_CLK), .LATCH_STROBE(LATCH_STROBE),
    .BLANK(BLANK), .DETECT(DETECT), .FLAGS(FLAGS), .SERIAL_OUT(SERIAL_OUT),
    .CHANNEL_OUTPUT(CHANNEL_OUTPUT), .POWER_SAVE(POWER_SAVE),
    .STATUS_VALID(STATUS_VALID), .CTRL_WORD(CTRL_WORD));
  ////////////////////////////////////////
  function automatic logic [15:0] exp_word(row_t w);
    case (w.sel)
      SEL_NONE:  return w.on;
      SEL_OPEN:  return w.fl.thermal_error_flag ? 16'hFFFF :
                   DETECT.below_open & ((w.cur != CUR_OFF) ? 16'hFFFF : w.on);
      SEL_SHORT: return w.fl.pre_thermal_warning ? 16'hFFFF :
                   DETECT.above_short[w.thr] & w.on;
      default:   return w.fl.ref_short_flag ? 16'hFFFF : DETECT.leak & ~w.on;
    endcase
  endfunction
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  initial
  begin
    #200000;
    error_cnt++;
    complete_run();
  end
  initial
  begin
    RESETN = 1'b0;
    FLAGS = '0;
    DETECT = {16'hA5C3, 16'h0F33, 16'hC3C3, 16'h5A5A, 16'h9966, 16'h3C96};
    repeat (8) @(posedge CLK);
    RESETN <= 1'b1;
    host.wait_c(2);
    chk(17'(CTRL_WORD), 17'(CTRL_RESET));
    chk(17'({POWER_SAVE, STATUS_VALID, SERIAL_OUT}), 17'h0);
    chk(17'(CHANNEL_OUTPUT), 17'h0);
    foreach (rows[k])
    begin
      FLAGS <= rows[k].fl;
      c = CTRL_RESET;
      c[CTRL_SEL_LO +: 2] = rows[k].sel;
      c[CTRL_THR_LO +: 2] = rows[k].thr;
      c[CTRL_CUR_LO +: 2] = rows[k].cur;
      c[CTRL_WIN_LO +: 2] = 2'h0;
      host.xfer({1'b1, c}, r);
      host.latch();
      chk(17'(CTRL_WORD), 17'(c));
      // Wait outlasts the blind time and wake delay after outputs are enabled
      host.xfer({1'b0, rows[k].on}, r);
      host.latch();
      host.wait_c(BLIND_CYCLES + WAKE);
      chk(17'(CHANNEL_OUTPUT), rows[k].fl.thermal_error_flag ? 17'h0 : 17'(rows[k].on));
      // Window of 17 oscillator periods ends well inside this wait
      host.blank();
      host.wait_c(300);
      host.xfer({1'b0, rows[k].on}, r);
      host.latch();
      host.xfer({1'b1, c}, r);
      host.latch();
      chk(r, {1'b0, exp_word(rows[k])});
    end
    chk(17'(STATUS_VALID), 17'h1);
    c = CTRL_RESET;
    host.xfer({1'b1, c}, r);
    host.latch();
    host.xfer(17'h0, r);
    host.latch();
    host.wait_c(50);
    chk(17'(POWER_SAVE), 17'h1);
    host.sclk();
    host.wait_c(5);
    chk(17'({POWER_SAVE, STATUS_VALID}), 17'h0);
    host.xfer({1'b1, c}, r);
    host.latch();
    chk(17'(POWER_SAVE), 17'h1);
    c[CTRL_PS_BIT] = 1'b0;
    host.xfer({1'b1, c}, r);
    host.latch();
    host.xfer(17'h0, r);
    host.latch();
    chk(17'(POWER_SAVE), 17'h0);
    complete_run();
  end
endmodule
`default_nettype wire
